// File: rtl/irs_pkg.sv
// shared constants and types for the two-wire register access link
package irs_pkg;

  // ------------------------------------------------------------
  // addressing
  // ------------------------------------------------------------
  // 7-bit device address; address byte reads 8'hD0 write, 8'hD1 read
  localparam logic [6:0] DEV_ADDR     = 7'h68;
  localparam logic [7:0] REG_LIMIT    = 8'h10;
  localparam logic [7:0] STBY_REG_LO  = 8'h01;
  localparam logic [7:0] STBY_REG_HI  = 8'h03;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam int         NUM_REGS     = 16;

  // ------------------------------------------------------------
  // bit framing
  // ------------------------------------------------------------
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_LAST_DAT = 4'h7;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int         CLK_PERIOD_NS    = 10;
  // bus clock must stay below core clock / 40
  localparam int         MCLK_PER_SCL_MIN = 40;
  // host bit cell is four quarters; 4 * 12 = 48 core cycles per bit
  localparam logic [4:0] SCL_QTR = 5'(MCLK_PER_SCL_MIN / 4 + 2);

  // ------------------------------------------------------------
  // host byte selector
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_ADDR = 2'h0;
  localparam logic [1:0] SEL_REG  = 2'h1;
  localparam logic [1:0] SEL_DATA = 2'h2;

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [8:0] {
    D_IDLE = 9'h001, D_ADDR = 9'h002, D_AACK = 9'h004,
    D_REG  = 9'h008, D_RACK = 9'h010, D_WDAT = 9'h020,
    D_WACK = 9'h040, D_RDAT = 9'h080, D_DACK = 9'h100
  } irs_dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_START = 5'h02, H_TX = 5'h04,
    H_RX   = 5'h08, H_STOP  = 5'h10
  } irs_host_state_t;

endpackage

// File: rtl/irs_if.sv
// open-drain two-wire bus joining the host and the device
`timescale 1ns/10ps
interface irs_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // pulled high unless a driver pulls low
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// File: rtl/irs_dev.sv
// device end: register access slave on the two-wire bus
// ------------------------------------------------------------
// What this block does
// - standby write: address 01-03, one data byte
// - normal write: many data bytes, each acknowledged
// - host sets pointer by short write first
// - read address returns bytes while host acknowledges
// - last read byte may go unacknowledged
// - host bus clock below core clock / 40
// - standby guarantees only the clock registers
// ------------------------------------------------------------
`timescale 1ns/10ps
module irs_dev (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  // two-wire bus
  irs_if.dev               BUS,
  // operating mode
  input  wire logic        STANDBY,
  // register update notice
  output logic             WR_STB,
  output logic [7:0]       WR_ADDR,
  output logic [7:0]       WR_DATA
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // register reachable in the present mode
  function automatic logic reg_ok(input logic [7:0] a, input logic stby);
    reg_ok = (a < irs_pkg::REG_LIMIT) &&
             (!stby || (a >= irs_pkg::STBY_REG_LO && a <= irs_pkg::STBY_REG_HI));
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  irs_pkg::irs_dev_state_t st_q;
  irs_pkg::irs_dev_state_t st_d;
  logic                    scl_q;
  logic                    sda_q;
  logic [7:0]              sr_q;
  logic [3:0]              cnt_q;
  logic                    rw_q;
  logic [7:0]              ptr_q;
  logic [7:0]              ptr_d;
  logic                    wrote_q;
  logic                    wrote_d;
  logic                    oe_q;
  logic                    oe_d;
  logic                    zero_q;
  logic                    wr_d;
  logic                    ld_d;
  logic [7:0]              regs_q [irs_pkg::NUM_REGS];

  // ------------------------------------------------------------
  // bus event decode
  // ------------------------------------------------------------
  wire       rise      = BUS.scl & ~scl_q;
  wire       fall      = ~BUS.scl & scl_q;
  wire       start     = BUS.scl & scl_q & sda_q & ~BUS.sda;
  wire       stop      = BUS.scl & scl_q & ~sda_q & BUS.sda;
  wire       byte_done = fall && (cnt_q == irs_pkg::BIT_ACK);
  wire       counting  = (st_q == irs_pkg::D_ADDR) || (st_q == irs_pkg::D_REG) ||
                         (st_q == irs_pkg::D_WDAT) || (st_q == irs_pkg::D_RDAT);
  wire       addr_hit  = (sr_q[7:1] == irs_pkg::DEV_ADDR);
  wire       ptr_ok    = reg_ok(ptr_q, STANDBY);
  wire       reg_hit   = reg_ok(sr_q, STANDBY);
  // only one data byte per standby write
  wire       wr_allow  = ptr_ok && !(STANDBY && wrote_q);
  wire [7:0] rd_byte   = ptr_ok ? regs_q[ptr_q[3:0]] : 8'h00;
  wire [7:0] ptr_inc   = ptr_q + 8'h01;
  wire       host_ack  = ~sda_q;

  // ------------------------------------------------------------
  // protocol state machine
  // ------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    oe_d    = oe_q;
    ptr_d   = ptr_q;
    wrote_d = wrote_q;
    wr_d    = 1'b0;
    ld_d    = 1'b0;
    if (stop) begin
      st_d = irs_pkg::D_IDLE;
      oe_d = 1'b0;
    end else if (start) begin
      st_d    = irs_pkg::D_ADDR;
      oe_d    = 1'b0;
      wrote_d = 1'b0;
    end else begin
      case (st_q)
        irs_pkg::D_IDLE: begin
          st_d = irs_pkg::D_IDLE;
        end
        irs_pkg::D_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              oe_d = 1'b1;
              st_d = irs_pkg::D_AACK;
            end else begin
              st_d = irs_pkg::D_IDLE;
            end
          end
        end
        irs_pkg::D_AACK: begin
          if (fall) begin
            if (rw_q) begin
              ld_d  = 1'b1;
              oe_d  = ~rd_byte[7];
              ptr_d = ptr_inc;
              st_d  = irs_pkg::D_RDAT;
            end else begin
              oe_d = 1'b0;
              st_d = irs_pkg::D_REG;
            end
          end
        end
        irs_pkg::D_REG: begin
          if (byte_done) begin
            if (reg_hit) begin
              ptr_d = sr_q;
              oe_d  = 1'b1;
              st_d  = irs_pkg::D_RACK;
            end else begin
              st_d = irs_pkg::D_IDLE;
            end
          end
        end
        irs_pkg::D_RACK: begin
          if (fall) begin
            oe_d = 1'b0;
            st_d = irs_pkg::D_WDAT;
          end
        end
        irs_pkg::D_WDAT: begin
          if (byte_done) begin
            if (wr_allow) begin
              wr_d    = 1'b1;
              wrote_d = 1'b1;
              ptr_d   = ptr_inc;
              oe_d    = 1'b1;
              st_d    = irs_pkg::D_WACK;
            end else begin
              st_d = irs_pkg::D_IDLE;
            end
          end
        end
        irs_pkg::D_WACK: begin
          if (fall) begin
            oe_d = 1'b0;
            st_d = irs_pkg::D_WDAT;
          end
        end
        irs_pkg::D_RDAT: begin
          if (fall) begin
            if (cnt_q == irs_pkg::BIT_ACK) begin
              oe_d = 1'b0;
              st_d = irs_pkg::D_DACK;
            end else begin
              oe_d = ~sr_q[7];
            end
          end
        end
        irs_pkg::D_DACK: begin
          if (fall) begin
            if (host_ack) begin
              ld_d  = 1'b1;
              oe_d  = ~rd_byte[7];
              ptr_d = ptr_inc;
              st_d  = irs_pkg::D_RDAT;
            end else begin
              st_d = irs_pkg::D_IDLE;
            end
          end
        end
        default: begin
          st_d = irs_pkg::D_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // state and pin registers
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q    <= irs_pkg::D_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      oe_q    <= 1'b0;
      zero_q  <= 1'b0;
      ptr_q   <= irs_pkg::REG_RESET;
      wrote_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      scl_q   <= BUS.scl;
      sda_q   <= BUS.sda;
      oe_q    <= oe_d;
      zero_q  <= 1'b0;
      ptr_q   <= ptr_d;
      wrote_q <= wrote_d;
    end
  end

  // ------------------------------------------------------------
  // shifter and bit counter
  // ------------------------------------------------------------
  // one left shift serves receive and transmit: after each rise
  // bit 7 holds the next bit to drive
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sr_q  <= 8'h00;
      cnt_q <= 4'h0;
      rw_q  <= 1'b0;
    end else begin
      if (ld_d) begin
        sr_q <= rd_byte;
      end else if (rise) begin
        sr_q <= {sr_q[6:0], BUS.sda};
      end
      if (start || byte_done) begin
        cnt_q <= 4'h0;
      end else if (rise && counting) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (st_q == irs_pkg::D_ADDR && byte_done) begin
        rw_q <= sr_q[0];
      end
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  for (genvar g = 0; g < irs_pkg::NUM_REGS; g++) begin : g_reg
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        regs_q[g] <= irs_pkg::REG_RESET;
      end else if (wr_d && ptr_q[3:0] == 4'(g)) begin
        regs_q[g] <= sr_q;
      end
    end
  end

  // ------------------------------------------------------------
  // update notice
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WR_STB  <= 1'b0;
      WR_ADDR <= 8'h00;
      WR_DATA <= 8'h00;
    end else begin
      WR_STB <= wr_d;
      if (wr_d) begin
        WR_ADDR <= ptr_q;
        WR_DATA <= sr_q;
      end
    end
  end

  assign BUS.dev_sda_o  = zero_q;
  assign BUS.dev_sda_oe = oe_q;

endmodule // irs_dev

// File: rtl/irs_host.sv
// host end: bus master issuing register writes and reads
`timescale 1ns/10ps
module irs_host (
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST_B,
  // two-wire bus
  irs_if.host             BUS,
  // command
  input  wire logic       STANDBY,
  input  wire logic       GO,
  input  wire logic       RD,
  input  wire logic [7:0] REG,
  input  wire logic [3:0] LEN,
  input  wire logic [7:0] WDATA,
  // answers
  output logic            WNEXT,
  output logic [7:0]      RDATA,
  output logic            RVALID,
  output logic            BUSY,
  output logic            DONE,
  output logic            NACK
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  irs_pkg::irs_host_state_t st_q, st_d;
  logic [4:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q, bit_d;
  logic [1:0] sel_q, sel_d;
  logic       rdp_q, rdp_d;
  logic [3:0] left_q, left_d;
  logic [7:0] sr_q, sr_d;
  logic       scl_q, scl_d;
  logic       sda_q, sda_d;
  logic       nack_d;
  logic       wn_d;
  logic       rv_d;
  logic       dn_d;
  logic       rd_q;
  logic [7:0] reg_q;
  logic       zero_q;

  // ------------------------------------------------------------
  // quarter-bit tick
  // ------------------------------------------------------------
  wire       idle    = (st_q == irs_pkg::H_IDLE);
  wire       tick    = !idle && div_q == irs_pkg::SCL_QTR - 5'h01;
  wire       go_ok   = GO && idle;
  wire       is_ack  = (bit_q == irs_pkg::BIT_ACK);
  wire       last    = (left_q == 4'h1);
  wire [3:0] len_eff = (LEN == 4'h0 || (STANDBY && !RD)) ? 4'h1 : LEN;
  wire [7:0] dev_adr = {irs_pkg::DEV_ADDR, rdp_q};

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q; bit_d = bit_q; sel_d = sel_q; rdp_d = rdp_q;
    left_d = left_q; sr_d = sr_q; scl_d = scl_q; sda_d = sda_q;
    nack_d = NACK; wn_d = 1'b0; rv_d = 1'b0; dn_d = 1'b0;
    if (go_ok) begin
      st_d = irs_pkg::H_START; rdp_d = 1'b0; nack_d = 1'b0;
      left_d = len_eff;
    end else if (tick) begin
      case (st_q)
        irs_pkg::H_START: begin
          if (ph_q == 2'h1) sda_d = 1'b1;
          if (ph_q == 2'h2) scl_d = 1'b1;
          if (ph_q == 2'h3) begin
            st_d = irs_pkg::H_TX; sel_d = irs_pkg::SEL_ADDR;
            sr_d = dev_adr; bit_d = 4'h0;
          end
        end
        irs_pkg::H_TX, irs_pkg::H_RX: begin
          if (ph_q == 2'h0) begin
            if (st_q == irs_pkg::H_TX) sda_d = !is_ack && !sr_q[7];
            else sda_d = is_ack && !last;
          end
          if (ph_q == 2'h1) scl_d = 1'b0;
          if (ph_q == 2'h2) sr_d = {sr_q[6:0], BUS.sda};
          if (ph_q == 2'h3) begin
            scl_d = 1'b1;
            // let go of data with the clock fall, before the device takes the line
            if (bit_q == irs_pkg::BIT_LAST_DAT || is_ack) sda_d = 1'b0;
            bit_d = bit_q + 4'h1;
            if (st_q == irs_pkg::H_RX && bit_q == irs_pkg::BIT_LAST_DAT) rv_d = 1'b1;
            if (is_ack) begin
              bit_d = 4'h0;
              if (st_q == irs_pkg::H_RX) begin
                left_d = left_q - 4'h1;
                if (last) st_d = irs_pkg::H_STOP;
              end else if (sr_q[0]) begin
                nack_d = 1'b1; st_d = irs_pkg::H_STOP;
              end else if (sel_q == irs_pkg::SEL_ADDR) begin
                if (rdp_q) st_d = irs_pkg::H_RX;
                else begin sel_d = irs_pkg::SEL_REG; sr_d = reg_q; end
              end else if (sel_q == irs_pkg::SEL_REG && rd_q) begin
                st_d = irs_pkg::H_STOP;
              end else begin
                if (sel_q == irs_pkg::SEL_DATA) left_d = left_q - 4'h1;
                if (sel_q == irs_pkg::SEL_DATA && last) st_d = irs_pkg::H_STOP;
                else begin
                  sel_d = irs_pkg::SEL_DATA; sr_d = WDATA; wn_d = 1'b1;
                end
              end
            end
          end
        end
        irs_pkg::H_STOP: begin
          if (ph_q == 2'h0) sda_d = 1'b1;
          if (ph_q == 2'h1) scl_d = 1'b0;
          if (ph_q == 2'h2) sda_d = 1'b0;
          if (ph_q == 2'h3) begin
            if (rd_q && !rdp_q && !NACK) begin
              rdp_d = 1'b1; st_d = irs_pkg::H_START;
            end else begin
              st_d = irs_pkg::H_IDLE; dn_d = 1'b1;
            end
          end
        end
        default: st_d = irs_pkg::H_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= irs_pkg::H_IDLE; div_q <= 5'h00; ph_q <= 2'h0;
      bit_q <= 4'h0; sel_q <= 2'h0; rdp_q <= 1'b0; left_q <= 4'h0;
      sr_q <= 8'h00; scl_q <= 1'b0; sda_q <= 1'b0; rd_q <= 1'b0;
      reg_q <= 8'h00; zero_q <= 1'b0;
    end else begin
      st_q <= st_d; bit_q <= bit_d; sel_q <= sel_d; rdp_q <= rdp_d;
      left_q <= left_d; sr_q <= sr_d; scl_q <= scl_d; sda_q <= sda_d;
      zero_q <= 1'b0;
      div_q <= (idle || tick) ? 5'h00 : div_q + 5'h01;
      ph_q  <= go_ok ? 2'h0 : (tick ? ph_q + 2'h1 : ph_q);
      if (go_ok) begin
        rd_q <= RD; reg_q <= REG;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WNEXT <= 1'b0; RDATA <= 8'h00; RVALID <= 1'b0;
      BUSY <= 1'b0; DONE <= 1'b0; NACK <= 1'b0;
    end else begin
      WNEXT <= wn_d; RVALID <= rv_d; DONE <= dn_d; NACK <= nack_d;
      BUSY <= (st_d != irs_pkg::H_IDLE);
      if (rv_d) RDATA <= sr_d;
    end
  end

  assign BUS.host_scl_o  = zero_q;
  assign BUS.host_sda_o  = zero_q;
  assign BUS.host_scl_oe = scl_q;
  assign BUS.host_sda_oe = sda_q;

endmodule // irs_host

// File: testbench/irs_bus_sva.sv
// concurrent checks on the open-drain two-wire bus between host and device
`timescale 1ns/10ps
module irs_bus_sva (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // bus signals
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ------------------------------------------------------------
  // level run counter of the resolved clock line
  // ------------------------------------------------------------
  logic       scl_prev_q;
  logic [5:0] run_q;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scl_prev_q <= 1'b1;
      run_q      <= 6'h3F;
    end else begin
      scl_prev_q <= scl;
      run_q      <= (scl != scl_prev_q) ? 6'h01 : run_q + {5'h00, run_q != 6'h3F};
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_scl_high_min; (!scl && scl_prev_q) |-> run_q >= 6'h14; endproperty
  property p_scl_low_min; (scl && !scl_prev_q) |-> run_q >= 6'h14; endproperty
  // device takes the line shortly after a clock fall
  property p_dev_take; $rose(dev_sda_oe) |-> !scl && run_q <= 6'h04; endproperty
  property p_dev_drop; $fell(dev_sda_oe) |-> !scl; endproperty
  property p_dev_hold; (scl && $past(scl)) |-> $stable(dev_sda_oe); endproperty
  property p_dev_o_low; dev_sda_oe |-> !dev_sda_o; endproperty
  property p_host_o_low; !(host_scl_o || host_sda_o); endproperty
  property p_no_clash; !(dev_sda_oe && host_sda_oe); endproperty

  a_scl_high_min: assert property (p_scl_high_min) else $error("clock high phase too short");
  a_scl_low_min: assert property (p_scl_low_min) else $error("clock low phase too short");
  a_dev_take: assert property (p_dev_take) else $error("device drive not just after clock fall");
  a_dev_drop: assert property (p_dev_drop) else $error("device released data while clock high");
  a_dev_hold: assert property (p_dev_hold) else $error("device drive changed while clock high");
  a_dev_o_low: assert property (p_dev_o_low) else $error("device drives a high level");
  a_host_o_low: assert property (p_host_o_low) else $error("host drives a high level");
  a_no_clash: assert property (p_no_clash) else $error("host and device drive data together");

  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_start: cover property (scl && scl_prev_q && $fell(sda));
  c_stop: cover property (scl && scl_prev_q && $rose(sda));
endmodule // irs_bus_sva

// File: testbench/test_i2c_register_access_slave.sv
// self-checking bench joining host and device ends over the two-wire bus
`timescale 1ns/10ps
module test_i2c_register_access_slave;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic       core_clk;
  logic       rst_b;
  logic       standby;
  logic       host_free;
  logic       go;
  logic       rd;
  logic [7:0] reg_a;
  logic [3:0] len;
  logic [7:0] wdata;
  logic       wnext;
  logic [7:0] rdata;
  logic       rvalid;
  logic       busy;
  logic       done;
  logic       nack;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] wbuf [4];
  logic [1:0] widx;
  logic [15:0] wq [$];
  logic [7:0]  rq [$];
  int         mismatches;
  int         total_checks;

  irs_if irs_if_i ();
  irs_dev irs_dev_i (.CORE_CLK(core_clk), .RST_B(rst_b), .BUS(irs_if_i.dev), .STANDBY(standby),
    .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
  irs_host irs_host_i (.CORE_CLK(core_clk), .RST_B(rst_b), .BUS(irs_if_i.host), .STANDBY(standby && !host_free),
    .GO(go), .RD(rd), .REG(reg_a), .LEN(len), .WDATA(wdata), .WNEXT(wnext), .RDATA(rdata),
    .RVALID(rvalid), .BUSY(busy), .DONE(done), .NACK(nack));
  irs_bus_sva irs_bus_sva_i (.CORE_CLK(core_clk), .RST_B(rst_b), .host_scl_o(irs_if_i.host_scl_o),
    .host_scl_oe(irs_if_i.host_scl_oe), .host_sda_o(irs_if_i.host_sda_o),
    .host_sda_oe(irs_if_i.host_sda_oe), .dev_sda_o(irs_if_i.dev_sda_o),
    .dev_sda_oe(irs_if_i.dev_sda_oe), .scl(irs_if_i.scl), .sda(irs_if_i.sda));

  initial begin
    core_clk = 1'b0;
    forever #(irs_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  // write bytes follow the host's consumption pulses
  assign wdata = wbuf[widx];
  always @(posedge core_clk) begin
    if (go === 1'b1) widx <= 2'h0;
    else if (wnext === 1'b1) widx <= widx + 2'h1;
    if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rvalid === 1'b1) rq.push_back(rdata);
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_cmd(input logic r, input logic [7:0] a, input logic [3:0] n);
    int k;
    @(posedge core_clk);
    rd <= r;
    reg_a <= a;
    len <= n;
    go <= 1'b1;
    wq.delete();
    rq.delete();
    @(posedge core_clk);
    go <= 1'b0;
    k = 0;
    @(negedge core_clk);
    chk({15'h0000, busy}, 16'h0001);
    while (done !== 1'b1 && k < 20000) begin
      @(negedge core_clk);
      k++;
    end
    chk({15'h0000, k < 20000}, 16'h0001);
    chk({15'h0000, busy}, 16'h0000);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset_read();
    chk({14'h0000, irs_if_i.scl, irs_if_i.sda}, 16'h0003);
    run_cmd(1'b1, 8'h00, 4'h2);
    chk(16'(rq.size()), 16'h0002);
    foreach (rq[i]) chk({8'h00, rq[i]}, 16'h0000);
    chk({15'h0000, nack}, 16'h0000);
    $display("test_reset_read done");
  endtask

  task automatic test_write_burst();
    wbuf = '{8'hAA, 8'hBB, 8'hCC, 8'hDD};
    run_cmd(1'b0, 8'h05, 4'h3);
    chk(16'(wq.size()), 16'h0003);
    foreach (wq[i]) chk(wq[i], {8'h05 + 8'(i), wbuf[i]});
    chk({15'h0000, nack}, 16'h0000);
    $display("test_write_burst done");
  endtask

  task automatic test_read_burst();
    run_cmd(1'b1, 8'h05, 4'h3);
    chk(16'(rq.size()), 16'h0003);
    foreach (rq[i]) chk({8'h00, rq[i]}, {8'h00, wbuf[i]});
    run_cmd(1'b1, 8'h06, 4'h1);
    chk(16'(rq.size()), 16'h0001);
    chk({8'h00, rq[0]}, 16'h00BB);
    $display("test_read_burst done");
  endtask

  task automatic test_standby_regs();
    @(posedge core_clk);
    standby <= 1'b1;
    for (int r = 1; r <= 3; r++) begin
      wbuf = '{8'h50 + 8'(r), 8'h11, 8'h22, 8'h33};
      run_cmd(1'b0, 8'(r), 4'h3);
      chk(16'(wq.size()), 16'h0001);
      chk(wq[0], {8'(r), 8'h50 + 8'(r)});
      chk({15'h0000, nack}, 16'h0000);
      run_cmd(1'b1, 8'(r), 4'h1);
      chk({8'h00, rq[0]}, {8'h00, 8'h50 + 8'(r)});
    end
    $display("test_standby_regs done");
  endtask

  task automatic test_standby_refused();
    wbuf = '{8'h77, 8'h77, 8'h77, 8'h77};
    run_cmd(1'b0, 8'h05, 4'h1);
    chk({15'h0000, nack}, 16'h0001);
    chk(16'(wq.size()), 16'h0000);
    // host left unlimited: device must refuse a second standby data byte
    wbuf = '{8'h99, 8'h98, 8'h97, 8'h96};
    @(posedge core_clk);
    host_free <= 1'b1;
    run_cmd(1'b0, 8'h02, 4'h2);
    chk(16'(wq.size()), 16'h0001);
    chk(wq[0], 16'h0299);
    chk({15'h0000, nack}, 16'h0001);
    @(posedge core_clk);
    host_free <= 1'b0;
    standby <= 1'b0;
    run_cmd(1'b1, 8'h05, 4'h1);
    chk({8'h00, rq[0]}, 16'h00AA);
    $display("test_standby_refused done");
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    mismatches = 0;
    total_checks = 0;
    rst_b = 1'b0;
    standby = 1'b0;
    go = 1'b0;
    rd = 1'b0;
    reg_a = 8'h00;
    len = 4'h1;
    host_free = 1'b0;
    wbuf = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    test_reset_read();
    test_write_burst();
    test_read_burst();
    test_standby_regs();
    test_standby_refused();
    print_verdict();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end
endmodule // test_i2c_register_access_slave
